/* File: hw/rtc_cfg_pkg.sv */
package rtc_cfg_pkg;

  // ==========================================================
  // Register offsets on the serial-bus register port
  localparam logic [7:0] ADDR_IRQ_AND_CLOCK_OUT_CONTROL = 8'h11;
  localparam logic [7:0] ADDR_ANALOG_TRIM               = 8'h12;
  localparam logic [7:0] ADDR_DIGITAL_TRIM              = 8'h13;
  localparam logic [7:0] ADDR_POWER_CONFIG              = 8'h14;
  localparam logic [7:0] ADDR_STATUS                    = 8'h3f;

  // ==========================================================
  // Field positions
  localparam int unsigned PULSED_IRQ_SELECT_BIT  = 7;
  localparam int unsigned ALARM1_IRQ_ENABLE_BIT  = 6;
  localparam int unsigned ALARM0_IRQ_ENABLE_BIT  = 5;
  localparam int unsigned FREQ_OUT_SEL_HI_BIT    = 4;
  localparam int unsigned FREQ_OUT_SEL_LO_BIT    = 3;
  localparam int unsigned ANALOG_TRIM_BIT5       = 5;
  localparam int unsigned DIGITAL_TRIM_SIGN_BIT  = 2;
  localparam int unsigned DIGITAL_TRIM_10PPM_BIT = 1;
  localparam int unsigned DIGITAL_TRIM_20PPM_BIT = 0;
  localparam int unsigned BUS_OFF_ON_BATTERY_BIT = 7;
  localparam int unsigned SUPPLY_SWITCH_MODE_BIT = 6;
  localparam int unsigned RESET_THRESHOLD_LSB    = 0;
  localparam int unsigned ALARM1_FLAG_BIT        = 6;
  localparam int unsigned ALARM0_FLAG_BIT        = 5;

  // ==========================================================
  // Writable bits and reset values
  localparam logic [7:0] CTRL_MASK  = 8'hf8;
  localparam logic [7:0] ATRIM_MASK = 8'h3f;
  localparam logic [7:0] DTRIM_MASK = 8'h07;
  localparam logic [7:0] POWER_MASK = 8'hc7;
  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam logic [7:0] ATRIM_RST  = 8'h00;
  localparam logic [7:0] DTRIM_RST  = 8'h00;
  localparam logic [7:0] POWER_RST  = 8'h40;

  // ==========================================================
  // Reset threshold levels in millivolts
  localparam logic [12:0] THRESH_MV_000 = 13'h1220;
  localparam logic [12:0] THRESH_MV_001 = 13'h111c;
  localparam logic [12:0] THRESH_MV_010 = 13'h0c12;
  localparam logic [12:0] THRESH_MV_011 = 13'h0b68;
  localparam logic [12:0] THRESH_MV_100 = 13'h0a46;

  // ==========================================================
  // Load capacitor formula in half-pF units
  localparam logic [6:0] CAP_OFFSET_HALF_PF = 7'h12;

  // ==========================================================
  // Timing on the link clock (doubled oscillator tick)
  localparam int unsigned OSC_HZ         = 65536;
  localparam int unsigned SEC_PERIOD_S   = 1;
  localparam int unsigned SEC_CYCLES     = SEC_PERIOD_S * OSC_HZ;
  localparam int unsigned FOUT_4K_HZ     = 4096;
  localparam int unsigned FOUT_4K_HALF   = OSC_HZ / FOUT_4K_HZ / 2;
  localparam int unsigned TRIM_PPM_STEP  = 10;
  localparam int unsigned PPM_SCALE      = 1000000;
  localparam int unsigned TRIM_ACC_STEP  = TRIM_PPM_STEP * OSC_HZ;
  localparam int unsigned SEC_W          = 18;
  localparam int unsigned ACC_W          = 22;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    FREQ_ALARM,
    FREQ_32K,
    FREQ_4K,
    FREQ_1HZ
  } freq_sel_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage

/* File: hw/rtc_cfg_core.sv */
`timescale 1ns/100ps

module rtc_cfg_core
  import rtc_cfg_pkg::*;
#(
  parameter int unsigned SEC_CYCLES_P = SEC_CYCLES
)
(
  // Clocks and reset
  input  wire logic        sys_clk_i,
  input  wire logic        osc_clk_i,
  input  wire logic        arst_n_i,
  // Register port from the serial-bus front end
  input  wire reg_req_t    reg_req_i,
  output logic [7:0]       reg_rdata_o,
  // Alarm comparators, link clock domain
  input  wire logic        alarm0_match_i,
  input  wire logic        alarm1_match_i,
  // Power switch state, asynchronous
  input  wire logic        on_battery_i,
  // Shared pin and second tick, link clock domain
  output logic             irq_or_clock_out_pin_o,
  output logic             sec_tick_o,
  // Analog and power controls
  output logic [6:0]       load_cap_half_pf_o,
  output logic             bus_enable_o,
  output logic             supply_switch_mode_o,
  output logic [12:0]      reset_threshold_mv_o
);

  // ==========================================================
  // Non-volatile registers
  logic [7:0] irq_and_clock_out_control;
  logic [7:0] analog_trim;
  logic [7:0] digital_trim;
  logic [7:0] power_config;

  // Only the storage reset sets these to their reset values; otherwise only register writes change them
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      irq_and_clock_out_control <= CTRL_RST;
      analog_trim               <= ATRIM_RST;
      digital_trim              <= DTRIM_RST;
      power_config              <= POWER_RST;
    end
    else if (reg_req_i.wr)
    begin
      unique case (reg_req_i.addr)
        ADDR_IRQ_AND_CLOCK_OUT_CONTROL: irq_and_clock_out_control <= reg_req_i.wdata & CTRL_MASK;
        ADDR_ANALOG_TRIM:               analog_trim  <= reg_req_i.wdata & ATRIM_MASK;
        ADDR_DIGITAL_TRIM:              digital_trim <= reg_req_i.wdata & DTRIM_MASK;
        // Threshold bits take any write, no protection check
        ADDR_POWER_CONFIG:              power_config <= reg_req_i.wdata & POWER_MASK;
        default:                        ;
      endcase
    end
  end

  // ==========================================================
  // Alarm events and battery level into the system clock
  logic       alarm0_toggle;
  logic       alarm1_toggle;
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [2:0] sync3;
  logic [2:0] accepted;
  logic [2:0] accepted_d;
  logic       alarm0_event;
  logic       alarm1_event;
  logic       on_battery;

  always_ff @(posedge osc_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      alarm0_toggle <= 1'b0;
      alarm1_toggle <= 1'b0;
    end
    else
    begin
      alarm0_toggle <= alarm0_toggle ^ alarm0_match_i;
      alarm1_toggle <= alarm1_toggle ^ alarm1_match_i;
    end
  end

  // A change counts once the second and third stage agree
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sync1      <= 3'h0;
      sync2      <= 3'h0;
      sync3      <= 3'h0;
      accepted   <= 3'h0;
      accepted_d <= 3'h0;
    end
    else
    begin
      sync1      <= {on_battery_i, alarm1_toggle, alarm0_toggle};
      sync2      <= sync1;
      sync3      <= sync2;
      accepted   <= (sync2 & sync3) | (accepted & (sync2 | sync3));
      accepted_d <= accepted;
    end
  end

  assign alarm0_event = accepted[0] ^ accepted_d[0];
  assign alarm1_event = accepted[1] ^ accepted_d[1];
  assign on_battery   = accepted[2];

  // ==========================================================
  // Alarm flags, cleared by a status read
  logic alarm0_flag;
  logic alarm1_flag;
  logic status_read;

  assign status_read = reg_req_i.rd && (reg_req_i.addr == ADDR_STATUS);

  // Set beats the read-clear so a match during the read is kept
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      alarm0_flag <= 1'b0;
      alarm1_flag <= 1'b0;
    end
    else
    begin
      alarm0_flag <= alarm0_event | (alarm0_flag & ~status_read);
      alarm1_flag <= alarm1_event | (alarm1_flag & ~status_read);
    end
  end

  // ==========================================================
  // Read data
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      reg_rdata_o <= 8'h00;
    else if (reg_req_i.rd)
    begin
      unique case (reg_req_i.addr)
        ADDR_IRQ_AND_CLOCK_OUT_CONTROL: reg_rdata_o <= irq_and_clock_out_control;
        ADDR_ANALOG_TRIM:               reg_rdata_o <= analog_trim;
        ADDR_DIGITAL_TRIM:              reg_rdata_o <= digital_trim;
        ADDR_POWER_CONFIG:              reg_rdata_o <= power_config;
        ADDR_STATUS:                    reg_rdata_o <= {1'b0, alarm1_flag, alarm0_flag, 5'h00};
        default:                        reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // ==========================================================
  // Analog and power outputs
  function automatic logic [12:0] threshold_mv(input logic [2:0] code);
    logic [12:0] mv;
    mv = THRESH_MV_000;
    unique case (code)
      3'h1:    mv = THRESH_MV_001;
      3'h2:    mv = THRESH_MV_010;
      3'h3:    mv = THRESH_MV_011;
      3'h4:    mv = THRESH_MV_100;
      default: mv = THRESH_MV_000;
    endcase
    return mv;
  endfunction

  logic [6:0] next_load_cap;

  // Same code drives both crystal-pin arrays; low five bits are already half-pF units
  always_comb
  begin
    next_load_cap = CAP_OFFSET_HALF_PF
                  + {1'b0, ~analog_trim[ANALOG_TRIM_BIT5], 5'h00}
                  + {2'b00, analog_trim[4:0]};
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      load_cap_half_pf_o   <= 7'h00;
      bus_enable_o         <= 1'b1;
      supply_switch_mode_o <= POWER_RST[SUPPLY_SWITCH_MODE_BIT];
      reset_threshold_mv_o <= THRESH_MV_000;
    end
    else
    begin
      load_cap_half_pf_o   <= next_load_cap;
      bus_enable_o         <= ~(on_battery & power_config[BUS_OFF_ON_BATTERY_BIT]);
      supply_switch_mode_o <= power_config[SUPPLY_SWITCH_MODE_BIT];
      reset_threshold_mv_o <= threshold_mv(power_config[RESET_THRESHOLD_LSB +: 3]);
    end
  end

  // ==========================================================
  // Settings into the link clock domain
  // Bits are quasi-static; a write may land a cycle apart per bit
  logic [9:0] cfg_meta;
  logic [9:0] cfg_link;

  always_ff @(posedge osc_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cfg_meta <= 10'h000;
      cfg_link <= 10'h000;
    end
    else
    begin
      cfg_meta <= {irq_and_clock_out_control[7:3], digital_trim[2:0], alarm1_flag, alarm0_flag};
      cfg_link <= cfg_meta;
    end
  end

  logic      flag0_link;
  logic      flag1_link;
  logic [2:0] dtrim_link;
  logic      freq_lo_link;
  logic      freq_hi_link;
  logic      alarm0_en_link;
  logic      alarm1_en_link;
  logic      pulsed_link;

  assign flag0_link   = cfg_link[0];
  assign flag1_link   = cfg_link[1];
  assign dtrim_link   = cfg_link[4:2];
  assign freq_lo_link = cfg_link[5];
  assign freq_hi_link = cfg_link[6];
  assign alarm0_en_link = cfg_link[7];
  assign alarm1_en_link = cfg_link[8];
  assign pulsed_link  = cfg_link[9];

  // ==========================================================
  // Trimmed one-second prescaler
  logic [SEC_W-1:0] sec_cnt;
  logic [SEC_W-1:0] sec_end;
  logic [ACC_W-1:0] trim_acc;
  logic [ACC_W-1:0] next_trim_acc;
  logic [1:0]       trim_mag;
  logic [1:0]       trim_steps;
  logic             sec_wrap;

  assign trim_mag = {dtrim_link[DIGITAL_TRIM_20PPM_BIT], dtrim_link[DIGITAL_TRIM_10PPM_BIT]};

  // Positive trim shortens a second by the pending counts, negative lengthens it
  always_comb
  begin
    sec_end = SEC_W'(SEC_CYCLES_P - 1);
    if (dtrim_link[DIGITAL_TRIM_SIGN_BIT])
      sec_end = SEC_W'(SEC_CYCLES_P - 1) + SEC_W'(trim_steps);
    else
      sec_end = SEC_W'(SEC_CYCLES_P - 1) - SEC_W'(trim_steps);
  end

  assign sec_wrap      = (sec_cnt >= sec_end);
  assign next_trim_acc = trim_acc + ACC_W'(TRIM_ACC_STEP) * ACC_W'(trim_mag);

  // Accumulator spreads ppm over seconds; magnitude zero never fires
  // One count is about 15 ppm, so the top setting needs two in most seconds
  always_ff @(posedge osc_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sec_cnt    <= '0;
      trim_acc   <= '0;
      trim_steps <= 2'h0;
      sec_tick_o <= 1'b0;
    end
    else if (sec_wrap)
    begin
      sec_cnt    <= '0;
      sec_tick_o <= 1'b1;
      if (next_trim_acc >= ACC_W'(2 * PPM_SCALE))
      begin
        trim_acc   <= next_trim_acc - ACC_W'(2 * PPM_SCALE);
        trim_steps <= 2'h2;
      end
      else if (next_trim_acc >= ACC_W'(PPM_SCALE))
      begin
        trim_acc   <= next_trim_acc - ACC_W'(PPM_SCALE);
        trim_steps <= 2'h1;
      end
      else
      begin
        trim_acc   <= next_trim_acc;
        trim_steps <= 2'h0;
      end
    end
    else
    begin
      sec_cnt    <= sec_cnt + 1'b1;
      sec_tick_o <= 1'b0;
    end
  end

  // ==========================================================
  // Shared output pin
  logic [3:0] fast_cnt;
  logic       any_enable;
  logic       pulse_match;
  logic       held_low;
  freq_sel_t  freq_sel;

  assign freq_sel    = freq_sel_t'({freq_hi_link, freq_lo_link});
  assign any_enable  = alarm0_en_link | alarm1_en_link;
  assign pulse_match = alarm0_en_link ? alarm0_match_i : (alarm1_en_link & alarm1_match_i);
  assign held_low    = (alarm0_en_link & flag0_link) | (alarm1_en_link & flag1_link);

  always_ff @(posedge osc_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      fast_cnt <= 4'h0;
    else
      fast_cnt <= fast_cnt + 4'h1;
  end

  always_ff @(posedge osc_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      irq_or_clock_out_pin_o <= 1'b1;
    else
    begin
      unique case (freq_sel)
        FREQ_ALARM:
        begin
          if (!any_enable)
            irq_or_clock_out_pin_o <= 1'b1;
          else if (pulsed_link)
            irq_or_clock_out_pin_o <= ~pulse_match;
          else
            irq_or_clock_out_pin_o <= ~held_low;
        end
        FREQ_32K: irq_or_clock_out_pin_o <= ~irq_or_clock_out_pin_o;
        FREQ_4K:  irq_or_clock_out_pin_o <= fast_cnt[$clog2(FOUT_4K_HALF)];
        FREQ_1HZ: irq_or_clock_out_pin_o <= (sec_cnt < SEC_W'(SEC_CYCLES_P / 2));
      endcase
    end
  end

endmodule

/* File: tb/rtc_cfg_core_monitor.sv */
`timescale 1ns/100ps
module rtc_cfg_core_monitor
  import rtc_cfg_pkg::*;
#(
  parameter int unsigned SEC_CYCLES_P = SEC_CYCLES
)
(
  // Clocks and reset
  input wire logic        sys_clk_i,
  input wire logic        osc_clk_i,
  input wire logic        arst_n_i,
  // Register port
  input wire reg_req_t    reg_req_i,
  input wire logic [7:0]  reg_rdata_o,
  // Pin, tick and controls
  input wire logic        on_battery_i,
  input wire logic        irq_or_clock_out_pin_o,
  input wire logic        sec_tick_o,
  input wire logic [6:0]  load_cap_half_pf_o,
  input wire logic        bus_enable_o,
  input wire logic [12:0] reset_threshold_mv_o
);
  logic             sys_up;
  logic             tick_seen;
  logic [SEC_W-1:0] tick_gap;

  // ========
  // Helpers
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      sys_up <= 1'b0;
    else
      sys_up <= 1'b1;
  end

  // First tick after reset has no reference second
  always_ff @(posedge osc_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      tick_gap  <= '0;
      tick_seen <= 1'b0;
    end
    else if (sec_tick_o)
    begin
      tick_gap  <= SEC_W'(1);
      tick_seen <= 1'b1;
    end
    else
      tick_gap <= tick_gap + 1'b1;
  end

  // ========
  // Assertions
  property p_wr_rd(logic [7:0] a, logic [7:0] m);
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    (reg_req_i.wr && reg_req_i.addr == a) ##1 (reg_req_i.rd && !reg_req_i.wr && reg_req_i.addr == a)
    |=> reg_rdata_o == ($past(reg_req_i.wdata, 2) & m);
  endproperty

  chk_ctrl_readback : assert property (p_wr_rd(8'h11, 8'hf8))
    else $error("control readback wrong");
  chk_atrim_readback : assert property (p_wr_rd(8'h12, 8'h3f))
    else $error("analog trim readback wrong");
  chk_dtrim_readback : assert property (p_wr_rd(8'h13, 8'h07))
    else $error("digital trim readback wrong");
  chk_power_readback : assert property (p_wr_rd(8'h14, 8'hc7))
    else $error("power readback wrong");
  chk_unmapped_zero : assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    reg_req_i.rd && !(reg_req_i.addr inside {8'h11, 8'h12, 8'h13, 8'h14, 8'h3f}) |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  chk_rdata_stands : assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    !reg_req_i.rd |=> $stable(reg_rdata_o))
    else $error("read data moved without read");
  chk_bus_on_mains : assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (!on_battery_i)[*6] |-> bus_enable_o)
    else $error("bus off while on mains");
  chk_thresh_legal : assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    sys_up |-> reset_threshold_mv_o inside {13'h1220, 13'h111c, 13'h0c12, 13'h0b68, 13'h0a46})
    else $error("threshold not a legal level");
  chk_cap_range : assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    sys_up |-> load_cap_half_pf_o inside {[7'h12:7'h51]})
    else $error("load cap out of range");
  chk_second_len : assert property (@(posedge osc_clk_i) disable iff (!arst_n_i)
    tick_seen && sec_tick_o |-> tick_gap >= SEC_CYCLES_P - 2 && tick_gap <= SEC_CYCLES_P + 2)
    else $error("second length off by more than two");

  cov_pin_low : cover property (@(posedge osc_clk_i) disable iff (!arst_n_i) $fell(irq_or_clock_out_pin_o));
  cov_bus_off : cover property (@(posedge sys_clk_i) disable iff (!arst_n_i) $fell(bus_enable_o));
  cov_tick    : cover property (@(posedge osc_clk_i) disable iff (!arst_n_i) tick_seen && sec_tick_o);
endmodule

bind rtc_cfg_core rtc_cfg_core_monitor #(.SEC_CYCLES_P(SEC_CYCLES_P)) u_mon (
  .sys_clk_i(sys_clk_i), .osc_clk_i(osc_clk_i), .arst_n_i(arst_n_i),
  .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o), .on_battery_i(on_battery_i),
  .irq_or_clock_out_pin_o(irq_or_clock_out_pin_o), .sec_tick_o(sec_tick_o),
  .load_cap_half_pf_o(load_cap_half_pf_o), .bus_enable_o(bus_enable_o),
  .reset_threshold_mv_o(reset_threshold_mv_o));

/* File: tb/alarm_src.sv */
`timescale 1ns/100ps
module alarm_src
(
  // Link clock
  input  wire logic osc_clk_i,
  // Requests, one toggle per match
  input  wire logic fire0_i,
  input  wire logic fire1_i,
  // Match pulses
  output logic      alarm0_match_o,
  output logic      alarm1_match_o
);
  logic seen0 = 1'b0;
  logic seen1 = 1'b0;

  // Toggle handshake keeps the request safe across the unrelated clocks
  always_ff @(posedge osc_clk_i)
  begin
    seen0          <= fire0_i;
    seen1          <= fire1_i;
    alarm0_match_o <= fire0_i != seen0;
    alarm1_match_o <= fire1_i != seen1;
  end
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/100ps
module tb_top
  import rtc_cfg_pkg::*;
;
  logic        sys_clk_i = 1'b0;
  logic        osc_clk_i = 1'b0;
  logic        arst_n_i  = 1'b0;
  logic        on_bat    = 1'b0;
  logic        f0        = 1'b0;
  logic        f1        = 1'b0;
  reg_req_t    req       = '0;
  logic        m0, m1, pin, tick, bus_en, sw;
  logic [7:0]  rdata, d;
  logic [6:0]  cap;
  logic [12:0] mv;
  int          n_errors  = 0;
  int          n_tests   = 0;

  initial forever #25 sys_clk_i = ~sys_clk_i;
  initial
  begin
    #13;
    forever #40 osc_clk_i = ~osc_clk_i;
  end

  alarm_src u_src (.osc_clk_i(osc_clk_i), .fire0_i(f0), .fire1_i(f1), .alarm0_match_o(m0), .alarm1_match_o(m1));
  rtc_cfg_core #(.SEC_CYCLES_P(64)) dut (.sys_clk_i(sys_clk_i), .osc_clk_i(osc_clk_i), .arst_n_i(arst_n_i),
    .reg_req_i(req), .reg_rdata_o(rdata), .alarm0_match_i(m0), .alarm1_match_i(m1), .on_battery_i(on_bat),
    .irq_or_clock_out_pin_o(pin), .sec_tick_o(tick), .load_cap_half_pf_o(cap), .bus_enable_o(bus_en),
    .supply_switch_mode_o(sw), .reset_threshold_mv_o(mv));

  // ========
  // Shared tasks
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk_i) req <= '{1'b1, 1'b0, a, v};
    @(posedge sys_clk_i) req <= '0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge sys_clk_i) req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge sys_clk_i) req <= '0;
    @(posedge sys_clk_i) #1 d = rdata;
  endtask
  // Read straight after the write, the awkward back-to-back case
  task wrd(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk_i) req <= '{1'b1, 1'b0, a, v};
    @(posedge sys_clk_i) req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge sys_clk_i) req <= '0;
    @(posedge sys_clk_i) #1 d = rdata;
  endtask
  task ow(input int n);
    repeat (n) @(posedge osc_clk_i);
    #1;
  endtask
  task fire(input logic which);
    @(posedge sys_clk_i)
    if (which) f1 <= ~f1;
    else f0 <= ~f0;
  endtask
  task tog(input int n, output int c);
    logic p;
    c = 0;
    ow(1);
    p = pin;
    repeat (n)
    begin
      ow(1);
      if (pin !== p) c++;
      p = pin;
    end
  endtask
  task gap(output int g);
    g = 0;
    do begin ow(1); g++; end while (tick !== 1'b1 && g < 200);
    g = 0;
    do begin ow(1); g++; end while (tick !== 1'b1 && g < 200);
  endtask

  // ========
  // Scenarios
  task t_reset;
    rd(ADDR_IRQ_AND_CLOCK_OUT_CONTROL); chk(d, 8'h00);
    rd(ADDR_ANALOG_TRIM); chk(d, 8'h00);
    rd(ADDR_DIGITAL_TRIM); chk(d, 8'h00);
    rd(ADDR_POWER_CONFIG); chk(d, 8'h40);
    chk(mv, 16'h1220);
    chk(cap, 16'h0032);
    chk({bus_en, sw}, 16'h0003);
    wr(8'h20, 8'hff);
    rd(8'h20); chk(d, 8'h00);
    $display("test reset done");
  endtask
  task t_power;
    logic [12:0] lv [8];
    lv = '{13'h1220, 13'h111c, 13'h0c12, 13'h0b68, 13'h0a46, 13'h1220, 13'h1220, 13'h1220};
    for (int i = 0; i < 8; i++)
    begin
      wrd(ADDR_POWER_CONFIG, 8'(i)); chk(d, 8'(i));
      ow(4);
      chk(mv, lv[i]);
      chk(sw, 1'b0);
    end
    wrd(ADDR_POWER_CONFIG, 8'h80);
    @(posedge sys_clk_i) on_bat <= 1'b1;
    ow(6); chk(bus_en, 1'b0);
    wr(ADDR_POWER_CONFIG, 8'h40);
    ow(4); chk({bus_en, sw}, 16'h0003);
    @(posedge sys_clk_i) on_bat <= 1'b0;
    $display("test power done");
  endtask
  task t_cap;
    logic [5:0] b [5];
    b = '{6'h00, 6'h20, 6'h1f, 6'h3f, 6'h15};
    for (int i = 0; i < 5; i++)
    begin
      wrd(ADDR_ANALOG_TRIM, {2'b11, b[i]}); chk(d, {2'b00, b[i]});
      ow(2);
      chk(cap, 16'(2 * {~b[i][5], b[i][4:1]} + b[i][0] + 18));
    end
    $display("test cap done");
  endtask
  task t_freq;
    int          c;
    logic [15:0] ex [4];
    int          win [4];
    ex = '{16'h0000, 16'h0010, 16'h0002, 16'h0004};
    win = '{16, 16, 16, 128};
    for (int i = 0; i < 4; i++)
    begin
      wrd(ADDR_IRQ_AND_CLOCK_OUT_CONTROL, 8'h20 | 8'(i << 3));
      ow(8);
      if (i != 0) fire(1'b0);
      tog(win[i], c);
      chk(16'(c), ex[i]);
    end
    wr(ADDR_IRQ_AND_CLOCK_OUT_CONTROL, 8'h00);
    rd(ADDR_STATUS);
    $display("test freq done");
  endtask
  task t_alarm;
    int c;
    wr(ADDR_IRQ_AND_CLOCK_OUT_CONTROL, 8'h20);
    fire(1'b0); ow(10); chk(pin, 1'b0);
    ow(10); chk(pin, 1'b0);
    rd(ADDR_STATUS); chk(d & 8'h60, 8'h20);
    ow(10); chk(pin, 1'b1);
    wr(ADDR_IRQ_AND_CLOCK_OUT_CONTROL, 8'h00);
    fire(1'b1); ow(10); chk(pin, 1'b1);
    rd(ADDR_STATUS); chk(d & 8'h60, 8'h40);
    wr(ADDR_IRQ_AND_CLOCK_OUT_CONTROL, 8'he0);
    ow(8);
    repeat (2)
    begin
      fire(1'b0); tog(12, c); chk(16'(c), 16'h0002);
    end
    fire(1'b1); tog(12, c); chk(16'(c), 16'h0000);
    wr(ADDR_IRQ_AND_CLOCK_OUT_CONTROL, 8'h80);
    ow(8);
    fire(1'b0); tog(12, c); chk(16'(c), 16'h0000);
    rd(ADDR_STATUS);
    $display("test alarm done");
  endtask
  task t_trim;
    int          g;
    logic [7:0]  code [3];
    logic [15:0] ex [3];
    code = '{8'h04, 8'h03, 8'h07};
    ex = '{16'h0040, 16'h003e, 16'h0042};
    for (int i = 0; i < 3; i++)
    begin
      wr(ADDR_DIGITAL_TRIM, code[i]);
      gap(g);
      gap(g); chk(16'(g), ex[i]);
    end
    $display("test trim done");
  endtask

  task test_done;
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    #2000000;
    n_errors++;
    test_done;
  end

  initial
  begin
    repeat (16) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    t_reset;
    t_power;
    t_cap;
    t_freq;
    t_alarm;
    t_trim;
    test_done;
  end
endmodule
